// ---- rtl/slow_tick_params.svh ----
// Offsets, field positions, reset values and timing figures of the slow tick block
`ifndef SLOW_TICK_PARAMS_SVH
`define SLOW_TICK_PARAMS_SVH

// Clock rates in kHz
`define CLK_FREQ_KHZ     10000
`define REF_FREQ_KHZ     256

// Half period of the fastest slow clock (1000 Hz) in 256 kHz ticks
`define BASE_HALF_TICKS  128

// Register indices; byte address is four times the index
`define IDX_RATE_SEL0    10'h014
`define IDX_ENABLE_SEL2  10'h016
`define IDX_MODE_CFG     10'h018
`define IDX_STATUS       10'h019

// Rate select register fields
`define BIT_DIV16        14
`define BIT_X4           13

// Enable register fields
`define BIT_HALF         12
`define BIT_SLOW_EN      0

// Mode register fields
`define BIT_DBL_PLAY     0
`define BIT_DBL_REC      1
`define LSB_SRATE        2
`define MSB_SRATE        4
`define LSB_SYSRATIO     5
`define MSB_SYSRATIO     8
`define BIT_REC_OSR      9
`define BIT_PLAY_OSR     10
`define BIT_EQ_EN        11
`define BIT_REC_L        12
`define BIT_REC_R        13
`define BIT_PLAY_L       14
`define BIT_PLAY_R       15
`define BIT_REC_TEST     16
`define BIT_REC_BIAS     17
`define MODE_WIDTH       18
`define MODE_RESET       18'h00274

// Codes demanded for doubled-rate operation
`define HR_SAMPLE_RATE   3'h5
`define HR_SYS_RATIO     4'h1

`endif

// ---- rtl/slow_tick_pkg.sv ----
// Types shared by the slow tick block
package slow_tick_pkg;
   typedef logic [31:0] word_t;
   typedef logic [2:0]  rate_shift_t;
   typedef enum logic [0:0]
   {
      APB_IDLE   = 1'b0,
      APB_ACCESS = 1'b1
   } apb_state_e;
endpackage

// ---- rtl/slow_tick_if.sv ----
// Signals between reference tick, slow clock divider and the control logic
`timescale 1ns/100ps
interface slow_tick_if;
   import slow_tick_pkg::*;
   logic        ref_tick;
   logic        enable;
   rate_shift_t shift;
   logic        slow_level;
   logic        slow_tick;
   modport gen (output ref_tick);
   modport div (input ref_tick, input enable, input shift, output slow_level, output slow_tick);
   modport ctl (input ref_tick, output enable, output shift, input slow_level, input slow_tick);
endinterface

// ---- rtl/ref_tick_gen.sv ----
// Fractional divider that makes the 256 kHz reference tick
`timescale 1ns/100ps
`include "slow_tick_params.svh"
module ref_tick_gen
#(
   parameter int CLK_FREQ_KHZ = `CLK_FREQ_KHZ,
   parameter int REF_FREQ_KHZ = `REF_FREQ_KHZ
)
(
   input  wire logic  clk_i,
   input  wire logic  rst_i,
   slow_tick_if.gen   ifc
);
   import slow_tick_pkg::*;

   localparam int GAP_MIN = (CLK_FREQ_KHZ / REF_FREQ_KHZ) - 1;
   localparam int GAP_MAX = CLK_FREQ_KHZ / REF_FREQ_KHZ;

   logic [15:0] acc_q;
   logic [15:0] acc_sum;
   logic        wrap;
   logic        tick_q;
   logic [15:0] gap_q;
   logic        seen_q;

   // Phase accumulator, wraps at the system rate
   assign acc_sum = acc_q + 16'(REF_FREQ_KHZ);
   assign wrap    = acc_sum >= 16'(CLK_FREQ_KHZ);

   // Tick on each wrap, average 256 kHz
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         acc_q  <= 16'h0000;
         tick_q <= 1'b0;
      end
      else
      begin
         acc_q  <= wrap ? 16'(acc_sum - 16'(CLK_FREQ_KHZ)) : acc_sum;
         tick_q <= wrap;
      end
   end

   assign ifc.ref_tick = tick_q;

   // Cycles since the previous tick, for the spacing check
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         gap_q  <= 16'h0000;
         seen_q <= 1'b0;
      end
      else
      begin
         gap_q  <= tick_q ? 16'h0000 : gap_q + 16'h0001;
         seen_q <= seen_q | tick_q;
      end
   end

   ref_spacing_a: assert property (@(posedge clk_i) disable iff (rst_i)
      tick_q && seen_q |-> gap_q >= 16'(GAP_MIN) && gap_q <= 16'(GAP_MAX))
      else $error("reference tick spacing off");
endmodule

// ---- rtl/slow_clock_div.sv ----
// Glitch-free programmable divider making the slow timeout clock
`timescale 1ns/100ps
`include "slow_tick_params.svh"
module slow_clock_div
#(
   parameter int BASE_HALF_TICKS = `BASE_HALF_TICKS
)
(
   input  wire logic  clk_i,
   input  wire logic  rst_i,
   slow_tick_if.div   ifc
);
   import slow_tick_pkg::*;

   logic        run_q;
   logic        level_q;
   logic        tick_q;
   logic [15:0] cnt_q;
   logic [15:0] half_q;
   logic [15:0] half_new;
   logic        at_end;

   // Half period in reference ticks for the requested rate
   assign half_new = 16'(BASE_HALF_TICKS) << ifc.shift;
   assign at_end   = ifc.ref_tick && (cnt_q == half_q - 16'h0001);

   // New rate takes hold only after a whole period; stop waits for the phase to finish
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         run_q   <= 1'b0;
         level_q <= 1'b0;
         tick_q  <= 1'b0;
         cnt_q   <= 16'h0000;
         half_q  <= 16'h0000;
      end
      else if (!run_q)
      begin
         tick_q  <= 1'b0;
         level_q <= 1'b0;
         cnt_q   <= 16'h0000;
         run_q   <= ifc.enable;
         half_q  <= half_new;
      end
      else if (at_end)
      begin
         cnt_q   <= 16'h0000;
         level_q <= ~level_q & ifc.enable;
         tick_q  <= ~level_q & ifc.enable;
         run_q   <= ifc.enable;
         if (level_q)
            half_q <= half_new;
      end
      else
      begin
         tick_q <= 1'b0;
         if (ifc.ref_tick)
            cnt_q <= cnt_q + 16'h0001;
      end
   end

   assign ifc.slow_level = level_q;
   assign ifc.slow_tick  = tick_q;

   rate_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      run_q && !(at_end && level_q) |=> $stable(half_q))
      else $error("rate changed inside a period");

   rate_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
      at_end && level_q |=> half_q == (16'(BASE_HALF_TICKS) << $past(ifc.shift)))
      else $error("half period does not match rate bits");

   idle_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !run_q |-> !level_q && !tick_q)
      else $error("slow clock active while stopped");
endmodule

// ---- rtl/slow_tick_clocking.sv ----
// Slow timeout clock and doubled-rate clocking control with an APB register slave
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
`include "slow_tick_params.svh"

module slow_tick_clocking
#(
   parameter int BASE_HALF_TICKS = `BASE_HALF_TICKS,
   parameter int CLK_FREQ_KHZ    = `CLK_FREQ_KHZ,
   parameter int REF_FREQ_KHZ    = `REF_FREQ_KHZ
)
(
   input  wire logic                 CLOCK_I,
   input  wire logic                 SYS_RST_I,
   input  wire logic                 PSEL_I,
   input  wire logic                 PENABLE_I,
   input  wire logic                 PWRITE_I,
   input  wire logic [11:0]          PADDR_I,
   input  wire slow_tick_pkg::word_t PWDATA_I,
   input  wire logic [3:0]           PSTRB_I,
   output logic                      PREADY_O,
   output slow_tick_pkg::word_t      PRDATA_O,
   output logic                      PSLVERR_O,
   output logic                      SLOW_TIMEOUT_CLOCK_O,
   output logic                      DEBOUNCE_TICK_O,
   output logic                      VOLUME_TICK_O,
   output logic                      SYSTEM_CLOCK_FROM_MCLK_O,
   output logic                      BASE_RATE_48K_O,
   output logic                      DOUBLE_RATE_O,
   output logic                      RECORD_OSR_128_O,
   output logic                      CONFIG_ERROR_O
);
   import slow_tick_pkg::*;

   apb_state_e            state_q;
   logic                  pready_q;
   word_t                 prdata_q;
   logic                  pslverr_q;
   logic                  rate_div16_q;
   logic                  rate_x4_q;
   logic                  half_sel_q;
   logic                  slow_en_q;
   logic [`MODE_WIDTH-1:0] mode_q;
   logic                  slow_clk_q;
   logic                  debounce_q;
   logic                  volume_q;
   logic                  system_clock_mclk_q;
   logic                  base_rate_q;
   logic                  double_rate_q;
   logic                  rec_osr128_q;
   logic                  cfg_err_q;

   slow_tick_if tick_bus ();

   // Merge write data into a register under the byte strobes
   function automatic word_t merge(input word_t old_v, input word_t new_v,
                                   input logic [3:0] strb);
      word_t m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return (old_v & ~m) | (new_v & m);
   endfunction

   // Word decode
   wire [9:0] word_idx = PADDR_I[11:2];
   wire       hit_rate = word_idx == `IDX_RATE_SEL0;
   wire       hit_en   = word_idx == `IDX_ENABLE_SEL2;
   wire       hit_mode = word_idx == `IDX_MODE_CFG;
   wire       hit_stat = word_idx == `IDX_STATUS;
   wire       hit_any  = hit_rate | hit_en | hit_mode | hit_stat;
   wire       setup    = PSEL_I & ~PENABLE_I & (state_q == APB_IDLE);
   wire       wr_stb   = (state_q == APB_ACCESS) & PSEL_I & PENABLE_I & PWRITE_I;

   // Mode fields
   wire       dbl_play    = mode_q[`BIT_DBL_PLAY];
   wire       dbl_rec     = mode_q[`BIT_DBL_REC];
   wire [2:0] sample_rate = mode_q[`MSB_SRATE:`LSB_SRATE];
   wire [3:0] sys_ratio   = mode_q[`MSB_SYSRATIO:`LSB_SYSRATIO];
   wire       rec_osr     = mode_q[`BIT_REC_OSR];
   wire       play_osr    = mode_q[`BIT_PLAY_OSR];
   wire       eq_en       = mode_q[`BIT_EQ_EN];
   wire       rec_l       = mode_q[`BIT_REC_L];
   wire       rec_r       = mode_q[`BIT_REC_R];
   wire       play_l      = mode_q[`BIT_PLAY_L];
   wire       play_r      = mode_q[`BIT_PLAY_R];
   wire       rec_test    = mode_q[`BIT_REC_TEST];
   wire       rec_bias    = mode_q[`BIT_REC_BIAS];
   wire       dbl_any     = dbl_play | dbl_rec;
   wire       base_code   = sample_rate == `HR_SAMPLE_RATE;

   // Software-side doubled-rate settings checked and reported
   wire err_both   = dbl_play & dbl_rec;
   wire err_play   = dbl_play & (rec_l | rec_r | play_osr);
   wire err_common = dbl_any & (eq_en | ~base_code | (sys_ratio != `HR_SYS_RATIO));
   wire err_rec    = dbl_rec & (play_l | play_r | rec_osr | rec_test | rec_bias);
   wire cfg_err    = err_both | err_play | err_common | err_rec;

   // Read views
   word_t rd_rate;
   word_t rd_en;
   word_t rd_mode;
   word_t rd_stat;
   word_t rd_mux;
   assign rd_rate = (32'(rate_div16_q) << `BIT_DIV16) | (32'(rate_x4_q) << `BIT_X4);
   assign rd_en   = (32'(half_sel_q) << `BIT_HALF) | (32'(slow_en_q) << `BIT_SLOW_EN);
   assign rd_mode = 32'(mode_q);
   assign rd_stat = {26'h0000000, rec_osr128_q, double_rate_q, base_rate_q,
                     cfg_err_q, system_clock_mclk_q, slow_clk_q};
   assign rd_mux  = hit_rate ? rd_rate :
                    hit_en   ? rd_en   :
                    hit_mode ? rd_mode :
                    hit_stat ? rd_stat : 32'h00000000;

   // Merged write values
   word_t wr_rate;
   word_t wr_en;
   word_t wr_mode;
   assign wr_rate = merge(rd_rate, PWDATA_I, PSTRB_I);
   assign wr_en   = merge(rd_en, PWDATA_I, PSTRB_I);
   assign wr_mode = merge(rd_mode, PWDATA_I, PSTRB_I);

   // APB handshake, answer in the first access cycle
   always_ff @(posedge CLOCK_I)
   begin
      if (SYS_RST_I)
      begin
         state_q   <= APB_IDLE;
         pready_q  <= 1'b0;
         prdata_q  <= 32'h00000000;
         pslverr_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            APB_IDLE:
            begin
               if (setup)
               begin
                  state_q   <= APB_ACCESS;
                  pready_q  <= 1'b1;
                  prdata_q  <= PWRITE_I ? 32'h00000000 : rd_mux;
                  pslverr_q <= ~hit_any;
               end
            end
            APB_ACCESS:
            begin
               state_q   <= APB_IDLE;
               pready_q  <= 1'b0;
               pslverr_q <= 1'b0;
            end
            default:
            begin
               state_q  <= APB_IDLE;
               pready_q <= 1'b0;
            end
         endcase
      end
   end

   // Register writes
   always_ff @(posedge CLOCK_I)
   begin
      if (SYS_RST_I)
      begin
         rate_div16_q <= 1'b0;
         rate_x4_q    <= 1'b0;
         half_sel_q   <= 1'b0;
         slow_en_q    <= 1'b0;
         mode_q       <= `MODE_RESET;
      end
      else if (wr_stb)
      begin
         if (hit_rate)
         begin
            rate_div16_q <= wr_rate[`BIT_DIV16];
            rate_x4_q    <= wr_rate[`BIT_X4];
         end
         else if (hit_en)
         begin
            half_sel_q <= wr_en[`BIT_HALF];
            slow_en_q  <= wr_en[`BIT_SLOW_EN];
         end
         else if (hit_mode)
            mode_q <= wr_mode[`MODE_WIDTH-1:0];
      end
   end

   // Divider control: shift weights 1 for halving, 2 for times-four, 4 for div16
   assign tick_bus.enable = slow_en_q;
   assign tick_bus.shift  = {rate_div16_q, ~rate_x4_q, ~half_sel_q};

   ref_tick_gen
   #(
      .CLK_FREQ_KHZ (CLK_FREQ_KHZ),
      .REF_FREQ_KHZ (REF_FREQ_KHZ)
   )
   u_ref
   (
      .clk_i (CLOCK_I),
      .rst_i (SYS_RST_I),
      .ifc   (tick_bus.gen)
   );

   slow_clock_div
   #(
      .BASE_HALF_TICKS (BASE_HALF_TICKS)
   )
   u_div
   (
      .clk_i (CLOCK_I),
      .rst_i (SYS_RST_I),
      .ifc   (tick_bus.div)
   );

   // Registered outputs
   always_ff @(posedge CLOCK_I)
   begin
      if (SYS_RST_I)
      begin
         slow_clk_q    <= 1'b0;
         debounce_q    <= 1'b0;
         volume_q      <= 1'b0;
         system_clock_mclk_q <= 1'b0;
         base_rate_q   <= 1'b0;
         double_rate_q <= 1'b0;
         rec_osr128_q  <= 1'b0;
         cfg_err_q     <= 1'b0;
      end
      else
      begin
         slow_clk_q    <= tick_bus.slow_level;
         debounce_q    <= tick_bus.slow_tick;
         volume_q      <= tick_bus.slow_tick;
         system_clock_mclk_q <= dbl_any;
         base_rate_q   <= base_code;
         double_rate_q <= base_code & dbl_any;
         rec_osr128_q  <= rec_osr;
         cfg_err_q     <= cfg_err;
      end
   end

   assign PREADY_O             = pready_q;
   assign PRDATA_O             = prdata_q;
   assign PSLVERR_O            = pslverr_q;
   assign SLOW_TIMEOUT_CLOCK_O = slow_clk_q;
   assign DEBOUNCE_TICK_O      = debounce_q;
   assign VOLUME_TICK_O        = volume_q;
   assign SYSTEM_CLOCK_FROM_MCLK_O   = system_clock_mclk_q;
   assign BASE_RATE_48K_O      = base_rate_q;
   assign DOUBLE_RATE_O        = double_rate_q;
   assign RECORD_OSR_128_O     = rec_osr128_q;
   assign CONFIG_ERROR_O       = cfg_err_q;

   // Checks next to the logic they guard
   apb_answer_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      setup |=> PREADY_O ##1 !PREADY_O)
      else $error("APB answer not in first access cycle");

   timeout_ticks_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      tick_bus.slow_tick |=> DEBOUNCE_TICK_O && VOLUME_TICK_O ##1 !DEBOUNCE_TICK_O)
      else $error("timeout ticks do not follow the slow clock");

   slow_enable_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      !slow_en_q && !tick_bus.slow_level |=> !tick_bus.slow_level)
      else $error("slow clock rose while disabled");

   // Shift weights: halving 1, times-four 2, div16 4
   rate_shift_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      int'(tick_bus.shift) == (half_sel_q ? 0 : 1) + (rate_x4_q ? 0 : 2) + (rate_div16_q ? 4 : 0))
      else $error("halving, times-four or div16 weight wrong");

   mclk_source_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      dbl_any |=> SYSTEM_CLOCK_FROM_MCLK_O)
      else $error("doubled rate not on master clock");

   mclk_release_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      !dbl_any |=> !SYSTEM_CLOCK_FROM_MCLK_O)
      else $error("master clock source kept without doubled rate");

   double_rate_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      DOUBLE_RATE_O |-> BASE_RATE_48K_O && $past(sample_rate) == `HR_SAMPLE_RATE)
      else $error("doubled rate without base code");

   record_osr_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      wr_stb && hit_mode |=> ##1 RECORD_OSR_128_O == $past(PWDATA_I[`BIT_REC_OSR], 2)
                                 || !$past(PSTRB_I[1], 2))
      else $error("record oversampling output wrong");

   // Error response follows the address decode of the setup cycle
   slave_error_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
      setup |=> PSLVERR_O == !$past(hit_any))
      else $error("error response does not match address decode");
endmodule

// ---- dv/test_slow_tick_clocking.sv ----
// Self-checking testbench for the slow tick and doubled-rate clocking block
`timescale 1ns/100ps
`include "slow_tick_params.svh"
module test_slow_tick_clocking;
   import slow_tick_pkg::*;

   localparam int          HALF_TICKS = 1;
   localparam int          MIN_PHASE  = 37;
   localparam logic [11:0] RATE_A     = {`IDX_RATE_SEL0, 2'b00};
   localparam logic [11:0] EN_A       = {`IDX_ENABLE_SEL2, 2'b00};
   localparam logic [11:0] MODE_A     = {`IDX_MODE_CFG, 2'b00};
   localparam logic [11:0] STAT_A     = {`IDX_STATUS, 2'b00};
   // Mode settings and expected {osr128, double, base, error, from_mclk}
   localparam logic [17:0] MODES [16] = '{18'h00274, 18'h00035, 18'h00835, 18'h00435,
      18'h01035, 18'h02035, 18'h00036, 18'h0C036, 18'h00236, 18'h10036, 18'h20036,
      18'h00037, 18'h00075, 18'h00031, 18'h00014, 18'h00836};
   localparam logic [4:0]  FLAGS [16] = '{5'h14, 5'h0D, 5'h0F, 5'h0F, 5'h0F, 5'h0F,
      5'h0D, 5'h0F, 5'h1F, 5'h0F, 5'h0F, 5'h0F, 5'h0F, 5'h03, 5'h04, 5'h0F};

   logic        clock;
   logic        rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   word_t       pwdata;
   logic [3:0]  pstrb;
   logic        pready;
   word_t       prdata;
   logic        pslverr;
   logic        slow_clk;
   logic        debounce;
   logic        volume;
   logic        sys_mclk;
   logic        base48;
   logic        dbl;
   logic        osr;
   logic        cfg_err;
   word_t       rdata;
   logic        perr;
   logic        last_lvl;
   int          ph;
   int          n_mismatch;
   int          tests_run;

   slow_tick_clocking #(.BASE_HALF_TICKS(HALF_TICKS)) u_slow_tick_clocking (
      .CLOCK_I(clock), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
      .PREADY_O(pready), .PRDATA_O(prdata), .PSLVERR_O(pslverr),
      .SLOW_TIMEOUT_CLOCK_O(slow_clk), .DEBOUNCE_TICK_O(debounce), .VOLUME_TICK_O(volume),
      .SYSTEM_CLOCK_FROM_MCLK_O(sys_mclk), .BASE_RATE_48K_O(base48), .DOUBLE_RATE_O(dbl),
      .RECORD_OSR_128_O(osr), .CONFIG_ERROR_O(cfg_err));

   // System clock, 100 ns period
   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // Verdict and end of run
   task results;
      if (n_mismatch == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task cmp(input word_t got, input word_t exp, input string what);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task cmp_range(input int got, input int lo, input int hi, input string what);
      tests_run++;
      if (got < lo || got > hi)
      begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %0d outside %0d..%0d", $time, what, got, lo, hi);
      end
   endtask

   task timeout(input string what);
      n_mismatch++;
      $display("mismatch at %0t: %s timed out", $time, what);
      results();
   endtask

   // One APB transfer, held until ready is sampled high
   task apb(input logic wr, input logic [11:0] addr, input word_t wd, input logic [3:0] strb);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      pstrb <= strb;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
         if (n > 16)
            timeout("apb ready");
      end
      while (pready !== 1'b1);
      rdata = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [11:0] a, input word_t d, input logic [3:0] s);
      apb(1'b1, a, d, s);
      cmp({31'h0, perr}, 32'h0, "write error");
   endtask

   task rd_chk(input logic [11:0] a, input word_t exp, input logic exp_err, input string what);
      apb(1'b0, a, 32'h0, 4'h0);
      cmp(rdata, exp, what);
      cmp({31'h0, perr}, {31'h0, exp_err}, "read error flag");
   endtask

   // Cycles up to the next slow tick, both tick outputs together
   task wait_tick(output int cyc);
      cyc = 0;
      do
      begin
         @(posedge clock);
         cyc++;
         if (cyc > 25000)
            timeout("slow tick");
      end
      while (debounce !== 1'b1);
      cmp({31'h0, volume}, 32'h1, "volume tick");
   endtask

   task quiet(input int n);
      logic seen;
      seen = 1'b0;
      repeat (n)
      begin
         @(posedge clock);
         if (debounce !== 1'b0 || slow_clk !== 1'b0)
            seen = 1'b1;
      end
      cmp({31'h0, seen}, 32'h0, "idle slow clock");
   endtask

   // Phase length watch across rate changes
   always @(posedge clock)
   begin
      if (rst)
      begin
         ph = 0;
         last_lvl = 1'b0;
      end
      else if (slow_clk !== last_lvl)
      begin
         cmp_range(ph, MIN_PHASE, 1000000, "slow clock phase");
         ph = 1;
         last_lvl = slow_clk;
      end
      else
         ph++;
   end

   // Main sequence
   initial
   begin
      int cyc;
      int exp_cyc;
      n_mismatch = 0;
      tests_run = 0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'h0;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      rd_chk(RATE_A, 32'h0, 1'b0, "rate reset");
      rd_chk(EN_A, 32'h0, 1'b0, "enable reset");
      quiet(400);
      rd_chk(12'h054, 32'h0, 1'b1, "unmapped read");
      wr(RATE_A, 32'h6000, 4'h1);
      rd_chk(RATE_A, 32'h0, 1'b0, "strobed write");
      wr(STAT_A, 32'hFFFFFFFF, 4'hF);
      // Doubled-rate settings, legal and illegal
      for (int i = 0; i < 16; i++)
      begin
         if (i > 0)
            wr(MODE_A, {14'h0, MODES[i]}, 4'hF);
         rd_chk(MODE_A, {14'h0, MODES[i]}, 1'b0, "mode readback");
         repeat (3) @(posedge clock);
         cmp({27'h0, osr, dbl, base48, cfg_err, sys_mclk}, {27'h0, FLAGS[i]},
             "mode pins");
         rd_chk(STAT_A, {26'h0, FLAGS[i], 1'b0}, 1'b0, "status");
      end
      // All eight slow clock rates, slowest first
      for (int s = 7; s >= 0; s--)
      begin
         wr(RATE_A, (s[2] ? 32'h4000 : 32'h0) | (s[1] ? 32'h0 : 32'h2000), 4'hF);
         wr(EN_A, (s[0] ? 32'h0 : 32'h1000) | 32'h1, 4'hF);
         wait_tick(cyc);
         wait_tick(cyc);
         wait_tick(cyc);
         exp_cyc = ((1 << s) * 625) / 8;
         cmp_range(cyc, exp_cyc - 2, exp_cyc + 2, "slow period");
      end
      wr(EN_A, 32'h1000, 4'hF);
      repeat (200) @(posedge clock);
      quiet(400);
      results();
   end
endmodule
